// ### misu_map.vh
// Register offsets, field positions and reset values of the metering interrupt status unit
`ifndef MISU_MAP_VH
`define MISU_MAP_VH

// Printed offsets are not multiples of four: these are word indices
`define MISU_IDX_ENABLE       8'h0a
`define MISU_IDX_FLAGS        8'h0b
`define MISU_IDX_FLAGS_RC     8'h0c
// Own register: sole interrupt mask of the bus-side interrupt output; the enable mask is not applied to it
`define MISU_IDX_BUS_MASK     8'h10

`define MISU_BIT_AE_HALF      0
`define MISU_BIT_SAG          1
`define MISU_BIT_CYC_DONE     2
`define MISU_BIT_WAVE_SMP     3
`define MISU_BIT_ZERO_CROSS   4
`define MISU_BIT_TEMP_DONE    5
`define MISU_BIT_RESET_DONE   6
`define MISU_BIT_AE_OVF       7
`define MISU_BIT_V_PEAK       8
`define MISU_BIT_I_PEAK       9
`define MISU_BIT_VA_HALF      10
`define MISU_BIT_VA_OVF       11
`define MISU_BIT_ZX_TIMEOUT   12
`define MISU_BIT_PWR_POS      13
`define MISU_BIT_PWR_NEG      14

// Bits that can ever raise the request: reset-done and reserved excluded
`define MISU_IRQ_CAPABLE      16'h7fbf
`define MISU_FLAG_IMPL        16'h7fff
`define MISU_ENABLE_RESET     16'h0000
`define MISU_FLAGS_RESET      16'h0000
`define MISU_BUS_MASK_RESET   16'h0000

`define MISU_RESP_OKAY        2'b00
`define MISU_RESP_SLVERR      2'b10

`endif

// ### misu_irq_status.v
// Metering interrupt flags, enable mask, active-low request and AXI4-Lite slave
// What this block does
// R1: Each monitored event raises its flag bit
// R2: Request low when raised flag is enabled
// R3: Host reads status first when servicing
// R4: Bit 0: active energy above half
// R5: Bit 1: line voltage dip detected
// R6: Bit 2: line-cycle accumulation finished
// R7: Bit 3: new waveform sample stored
// R8: Bit 4: rising and falling zero crossings
// R9: Bit 5: temperature result available
// R10: Bit 6: end of reset, never interrupts
// R11: Bit 7: active energy accumulator overflow
// R12: Bits 8, 9: voltage, current peak exceeded
// R13: Bits 10, 11: apparent half, overflow
// R14: Bit 12: zero crossing timeout
// R15: Bits 13, 14: power sign changes
// R16: Clear-on-read copy clears; plain read does not
// R17: Request returns high when none enabled
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "misu_map.vh"

module misu_irq_status (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        soft_reset,
   input  wire        active_energy_half_flag,
   input  wire        sag_event,
   input  wire        line_cycle_done_flag,
   input  wire        waveform_sample_flag,
   input  wire        zero_cross_flag,
   input  wire        temp_done_event,
   input  wire        active_energy_overflow_flag,
   input  wire        voltage_peak_flag,
   input  wire        current_peak_flag,
   input  wire        apparent_energy_half_flag,
   input  wire        apparent_energy_overflow_flag,
   input  wire        zero_cross_timeout_flag,
   input  wire        power_went_positive_flag,
   input  wire        power_went_negative_flag,
   output wire        irq_n_o,
   output wire        irq_n_oe,
   output wire        irq,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);

   // ==========================================================
   // Helpers
   // ==========================================================
   function [5:0] word_index;
      input [31:0] addr;
      begin
         word_index = addr[7:2];
      end
   endfunction

   function is_index;
      input [31:0] addr;
      input [7:0]  idx;
      begin
         is_index = (addr[31:8] == 24'h00_0000) && (addr[1:0] == 2'b00) && (word_index(addr) == idx[5:0]);
      end
   endfunction

   function [15:0] merge_bytes;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge_bytes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
         merge_bytes[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   // ==========================================================
   // Event capture
   // ==========================================================
   // Event inputs are level-type pulses from on-chip logic on aclk; edge detect so
   // a held level raises its flag only once, so clearing really clears
   wire [15:0] ev_level;
   reg  [15:0] ev_prev_q;
   reg         rst_seen_q;
   reg         rst_done_q;

   assign ev_level = {1'b0,
                      power_went_negative_flag,
                      power_went_positive_flag,
                      zero_cross_timeout_flag,                    // [R14]
                      apparent_energy_overflow_flag,
                      apparent_energy_half_flag,                  // [R13]
                      current_peak_flag,
                      voltage_peak_flag,                          // [R12]
                      active_energy_overflow_flag,                // [R11]
                      1'b0,
                      temp_done_event,                            // [R9]
                      1'b0,
                      waveform_sample_flag,                       // [R7]
                      line_cycle_done_flag,                       // [R6]
                      sag_event,                                  // [R5]
                      active_energy_half_flag};                   // [R4]

   // Zero crossing: both edges of the crossing signal count
   wire zx_any_edge = zero_cross_flag ^ ev_prev_q[`MISU_BIT_ZERO_CROSS];   // [R8]

   wire [15:0] ev_rise = ev_level & ~ev_prev_q;
   // Power sign flags are two separate edges; keep them apart  [R15]
   wire [15:0] ev_pulse = (ev_rise & ~(16'h0001 << `MISU_BIT_ZERO_CROSS))
                        | ({15'h0000, zx_any_edge} << `MISU_BIT_ZERO_CROSS)
                        | ({15'h0000, rst_done_q} << `MISU_BIT_RESET_DONE);   // [R10]

   always @(posedge aclk) begin
      if (!aresetn) begin
         // Levels already standing at reset are no new events
         ev_prev_q  <= ev_level | ({15'h0000, zero_cross_flag} << `MISU_BIT_ZERO_CROSS);
         rst_seen_q <= 1'b1;
         rst_done_q <= 1'b0;
      end else begin
         ev_prev_q  <= ev_level | ({15'h0000, zero_cross_flag} << `MISU_BIT_ZERO_CROSS);
         // End-of-reset pulse one cycle after hard or soft reset releases
         rst_seen_q <= soft_reset;
         rst_done_q <= rst_seen_q & ~soft_reset;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   reg        awready_q;
   reg        wready_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        aw_have_q;
   reg        w_have_q;
   reg [31:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg [15:0] enable_q;
   reg [15:0] bus_mask_q;

   wire aw_take = s_axi_awvalid & awready_q;
   wire w_take  = s_axi_wvalid & wready_q;
   wire wr_go   = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_en   = wr_go & is_index(awaddr_q, `MISU_IDX_ENABLE);
   wire wr_mask = wr_go & is_index(awaddr_q, `MISU_IDX_BUS_MASK);
   wire wr_ok   = wr_en | wr_mask | (wr_go & is_index(awaddr_q, `MISU_IDX_FLAGS_RC))
                | (wr_go & is_index(awaddr_q, `MISU_IDX_FLAGS));

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_q  <= 1'b1;
         wready_q   <= 1'b1;
         bvalid_q   <= 1'b0;
         bresp_q    <= `MISU_RESP_OKAY;
         aw_have_q  <= 1'b0;
         w_have_q   <= 1'b0;
         awaddr_q   <= 32'h0000_0000;
         wdata_q    <= 32'h0000_0000;
         wstrb_q    <= 4'h0;
         enable_q   <= `MISU_ENABLE_RESET;
         bus_mask_q <= `MISU_BUS_MASK_RESET;
      end else begin
         if (aw_take) begin
            awaddr_q  <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (w_take) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `MISU_RESP_OKAY : `MISU_RESP_SLVERR;
         end
         if (wr_en) begin
            enable_q <= merge_bytes(enable_q, wdata_q, wstrb_q);
         end
         if (wr_mask) begin
            bus_mask_q <= merge_bytes(bus_mask_q, wdata_q, wstrb_q);
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel and flag register
   // ==========================================================
   reg        arready_q;
   reg        rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0]  rresp_q;
   reg [15:0] flags_q;
   reg [15:0] flags_d;

   wire ar_take = s_axi_arvalid & arready_q;
   wire rd_flag = ar_take & is_index(s_axi_araddr, `MISU_IDX_FLAGS);
   wire rd_rc   = ar_take & is_index(s_axi_araddr, `MISU_IDX_FLAGS_RC);
   wire rd_en   = ar_take & is_index(s_axi_araddr, `MISU_IDX_ENABLE);
   wire rd_mask = ar_take & is_index(s_axi_araddr, `MISU_IDX_BUS_MASK);

   always @* begin
      flags_d = flags_q;
      // Only the copy read clears; plain status read keeps the flags  [R16]
      if (rd_rc) begin
         flags_d = `MISU_FLAGS_RESET;
      end
      // Set beats clear: an event in the clearing cycle survives  [R1]
      flags_d = (flags_d | ev_pulse) & `MISU_FLAG_IMPL;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `MISU_RESP_OKAY;
         flags_q   <= `MISU_FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
         if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= (rd_flag | rd_rc | rd_en | rd_mask) ? `MISU_RESP_OKAY : `MISU_RESP_SLVERR;
            if (rd_flag || rd_rc) begin
               rdata_q <= {16'h0000, flags_q};   // [R16]
            end else if (rd_en) begin
               rdata_q <= {16'h0000, enable_q};
            end else if (rd_mask) begin
               rdata_q <= {16'h0000, bus_mask_q};
            end else begin
               rdata_q <= 32'h0000_0000;
            end
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Interrupt request outputs
   // ==========================================================
   // Open-drain pin: drive low only while asserted, else released  [R2]
   reg irq_pin_q;
   reg irq_q;
   // Reset-done bit excluded from both outputs regardless of enable  [R10]
   wire [15:0] pending_d = flags_d & enable_q & `MISU_IRQ_CAPABLE;

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_pin_q <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         irq_pin_q <= |pending_d;                                    // [R2] [R17]
         irq_q     <= |(flags_d & bus_mask_q & `MISU_IRQ_CAPABLE);   // [R17]
      end
   end

   assign irq_n_o       = 1'b0;
   assign irq_n_oe      = irq_pin_q;
   assign irq           = irq_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule

// ### misu_host_pin.sv
// Host side of the open-drain request pin with its pull-up
`timescale 1ns/1ps
module misu_host_pin (
   input  wire irq_n_o,
   input  wire irq_n_oe,
   output wire irq_pin
);
   // Released pin floats to the pull-up level
   assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
endmodule

// ### misu_irq_status_sva.sv
// Port assertions of the metering interrupt status unit
`timescale 1ns/1ps
module misu_irq_status_sva (
   input wire aclk, aresetn, irq_n_o, irq_n_oe,
   input wire active_energy_half_flag, sag_event, line_cycle_done_flag, waveform_sample_flag,
   input wire zero_cross_flag, temp_done_event, active_energy_overflow_flag, voltage_peak_flag,
   input wire current_peak_flag, apparent_energy_half_flag, apparent_energy_overflow_flag,
   input wire zero_cross_timeout_flag, power_went_positive_flag, power_went_negative_flag,
   input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire [1:0] s_axi_rresp,
   input wire [31:0] s_axi_araddr
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg       zx_q;
   reg [2:0] quiet_q;
   // Zero crossing counts on both edges, so a change is a cause
   wire cause = active_energy_half_flag | sag_event | line_cycle_done_flag | waveform_sample_flag |
      temp_done_event | active_energy_overflow_flag | voltage_peak_flag | current_peak_flag |
      apparent_energy_half_flag | apparent_energy_overflow_flag | zero_cross_timeout_flag |
      power_went_positive_flag | power_went_negative_flag | (zero_cross_flag != zx_q);
   wire rc_take = s_axi_arvalid & s_axi_arready & (s_axi_araddr == 32'h0000_0030);
   always @(posedge aclk) begin
      zx_q <= zero_cross_flag;
      if (!aresetn || cause || s_axi_bvalid)
         quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
         quiet_q <= quiet_q + 3'h1;
   end
   sequence s_ar;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rc_quiet;
      s_ar ##0 (s_axi_araddr == 32'h0000_0030 && !cause) ##1 !cause;
   endsequence
   a_pin_data_low: assert property (irq_n_o == 1'b0) else $error("pin data not low");
   a_oe_has_cause: assert property ($rose(irq_n_oe) |-> quiet_q < 3'h4)
      else $error("request without event");
   a_rc_clears: assert property (s_rc_quiet |=> !irq_n_oe)
      else $error("request stays after clearing read");
   a_rd_answer: assert property (s_ar |=> s_axi_rvalid) else $error("read not answered");
   a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_rd_unmapped: assert property (s_ar ##0 (s_axi_araddr == 32'h0000_0014) |=> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // Request drops only after a clearing read or an enable write
   a_oe_fall_cause: assert property ($fell(irq_n_oe) |-> $past(rc_take) || $past(s_axi_bvalid))
      else $error("request dropped without clear");
endmodule
bind misu_irq_status misu_irq_status_sva u_sva (
   .aclk(aclk), .aresetn(aresetn), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
   .active_energy_half_flag(active_energy_half_flag), .sag_event(sag_event),
   .line_cycle_done_flag(line_cycle_done_flag), .waveform_sample_flag(waveform_sample_flag),
   .zero_cross_flag(zero_cross_flag), .temp_done_event(temp_done_event),
   .active_energy_overflow_flag(active_energy_overflow_flag), .voltage_peak_flag(voltage_peak_flag),
   .current_peak_flag(current_peak_flag), .apparent_energy_half_flag(apparent_energy_half_flag),
   .apparent_energy_overflow_flag(apparent_energy_overflow_flag),
   .zero_cross_timeout_flag(zero_cross_timeout_flag), .power_went_positive_flag(power_went_positive_flag),
   .power_went_negative_flag(power_went_negative_flag),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rresp(s_axi_rresp), .s_axi_araddr(s_axi_araddr)
);

// ### misu_irq_status_tb.sv
// Self-checking bench of the metering interrupt status unit
`timescale 1ns/1ps
`include "misu_map.vh"
module misu_irq_status_tb;
   logic aclk = 0, aresetn = 0, soft_reset = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [13:0] ev = 14'h0000;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   wire irq_n_o, irq_n_oe, irq, irq_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int miscompares = 0, check_count = 0, j;
   int bmap [14] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13, 14};
   always #2 aclk = ~aclk;
   misu_irq_status dut (.aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
      .active_energy_half_flag(ev[0]), .sag_event(ev[1]), .line_cycle_done_flag(ev[2]),
      .waveform_sample_flag(ev[3]), .zero_cross_flag(ev[4]), .temp_done_event(ev[5]),
      .active_energy_overflow_flag(ev[6]), .voltage_peak_flag(ev[7]), .current_peak_flag(ev[8]),
      .apparent_energy_half_flag(ev[9]), .apparent_energy_overflow_flag(ev[10]),
      .zero_cross_timeout_flag(ev[11]), .power_went_positive_flag(ev[12]), .power_went_negative_flag(ev[13]),
      .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   misu_host_pin host (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_pin(irq_pin));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
         if (s_axi_wvalid && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er);
   endtask
   task axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   task report_and_stop;
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      // Reset-done flag lands on the second edge after release
      repeat (2) @(posedge aclk);
      axr(32'h0000_002c, 32'h0000_0040, `MISU_RESP_OKAY);
      axw(32'h0000_0028, 32'h0000_7fff, `MISU_RESP_OKAY);
      axw(32'h0000_0040, 32'h0000_7fff, `MISU_RESP_OKAY);
      axr(32'h0000_0028, 32'h0000_7fff, `MISU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(irq_pin, 1);
      chk(irq, 0);
      axr(32'h0000_0030, 32'h0000_0040, `MISU_RESP_OKAY);
      axr(32'h0000_002c, 32'h0000_0000, `MISU_RESP_OKAY);
      // Pass 14 drops zero crossing again: the falling edge must flag too
      for (int i = 0; i < 15; i++) begin
         j = (i == 14) ? 4 : i;
         ev[j] <= (i != 14);
         @(posedge aclk);
         if (i != 4) ev[j] <= 0;
         repeat (3) @(posedge aclk);
         chk(irq_pin, 0);
         chk(irq, 1);
         axr(32'h0000_002c, 32'h1 << bmap[j], `MISU_RESP_OKAY);
         axr(32'h0000_0030, 32'h1 << bmap[j], `MISU_RESP_OKAY);
         repeat (3) @(posedge aclk);
         chk(irq_pin, 1);
         chk(irq, 0);
         axr(32'h0000_002c, 32'h0000_0000, `MISU_RESP_OKAY);
      end
      axw(32'h0000_0028, 32'h0000_0000, `MISU_RESP_OKAY);
      ev[1] <= 1;
      @(posedge aclk);
      ev[1] <= 0;
      repeat (3) @(posedge aclk);
      chk(irq_pin, 1);
      axr(32'h0000_002c, 32'h0000_0002, `MISU_RESP_OKAY);
      axw(32'h0000_0028, 32'h0000_0002, `MISU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(irq_pin, 0);
      axr(32'h0000_0030, 32'h0000_0002, `MISU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(irq_pin, 1);
      axw(32'h0000_0028, 32'h0000_7fff, `MISU_RESP_OKAY);
      soft_reset <= 1;
      @(posedge aclk);
      soft_reset <= 0;
      repeat (4) @(posedge aclk);
      chk(irq_pin, 1);
      axr(32'h0000_0030, 32'h0000_0040, `MISU_RESP_OKAY);
      axr(32'h0000_0014, 32'h0000_0000, `MISU_RESP_SLVERR);
      axw(32'h0000_0014, 32'h0000_ffff, `MISU_RESP_SLVERR);
      report_and_stop;
   end
endmodule
